// ==== hw/cfg_fuse_bank.sv ====
// Program-once configuration word bank with decoded option outputs
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module device_config_fuse_bank (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Nonvolatile store read port
   output logic [2:0]       nvm_addr,
   output logic             nvm_rd,
   input  wire logic [23:0] nvm_data,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Core requests
   input  wire logic        swap_instr_req,
   output logic             swap_instr_ok,
   output logic             swap_instr_reject,
   // Decoded options
   output logic             cfg_valid,
   output logic             scan_port_enable,
   output logic [2:0]       debug_channel_onehot,
   output logic [31:0]      deadman_window_interval,
   output logic [31:0]      deadman_instr_count_limit,
   output logic             deadman_timer_disable,
   output logic             second_spi_pin_route,
   output logic             smbus_threshold_enable,
   output logic [2:0]       i2c_default_location
);
   localparam int N = cfg_fuse_pkg::NUM_WORDS;
   // Implemented-bit mask per word, in store order
   localparam logic [23:0] MASKS [N] = '{
      cfg_fuse_pkg::IMPL_DEBUG,
      cfg_fuse_pkg::IMPL_HALF,
      cfg_fuse_pkg::IMPL_HALF,
      cfg_fuse_pkg::IMPL_HALF,
      cfg_fuse_pkg::IMPL_HALF,
      cfg_fuse_pkg::IMPL_DMT,
      cfg_fuse_pkg::IMPL_DEVOPT
   };

   cfg_word_if slot [N] ();
   logic [23:0] word [N];

   // Load sequencer state
   cfg_fuse_pkg::load_state_t st_r;
   cfg_fuse_pkg::load_state_t st_nxt;
   logic [2:0]  idx_r;
   logic [2:0]  idx_nxt;
   logic        rd_pend_r;
   logic        rd_pend_nxt;

   // Word holders, one per configuration word
   for (genvar g = 0; g < N; g++) begin : g_word
      assign slot[g].load     = rd_pend_r && (idx_r == 3'(g));
      assign slot[g].nvm_word = nvm_data;
      assign word[g]          = slot[g].held;
      cfg_word_hold #(.IMPL_MASK(MASKS[g])) u_hold (
         .clk   (clk),
         .rst_n (rst_n),
         .slot  (slot[g])
      );
   end

   // Load sequencer: one read per word after reset release, then frozen
   always_comb begin
      st_nxt      = st_r;
      idx_nxt     = idx_r;
      rd_pend_nxt = 1'b0;
      case (st_r)
         cfg_fuse_pkg::LD_IDLE: begin
            st_nxt = cfg_fuse_pkg::LD_READ;
         end
         cfg_fuse_pkg::LD_READ: begin
            rd_pend_nxt = 1'b1;
            if (rd_pend_r) begin
               // Last word captured here; the store port then goes quiet
               if (idx_r == 3'(N - 1)) begin
                  st_nxt      = cfg_fuse_pkg::LD_DONE;
                  rd_pend_nxt = 1'b0;
               end else begin
                  idx_nxt = idx_r + 3'h1;
               end
            end
         end
         cfg_fuse_pkg::LD_DONE: begin
            st_nxt = cfg_fuse_pkg::LD_DONE;
         end
         default: begin
            st_nxt = cfg_fuse_pkg::LD_IDLE;
         end
      endcase
   end

   // Address advances while the previous word is captured
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= cfg_fuse_pkg::LD_IDLE;
         idx_r     <= 3'h0;
         rd_pend_r <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         idx_r     <= idx_nxt;
         rd_pend_r <= rd_pend_nxt;
      end
   end

   // Store port next values
   logic [2:0] nvm_addr_nxt;
   logic       nvm_rd_nxt;

   // Store read strobe; data is taken in the same cycle as the address
   always_comb begin
      nvm_rd_nxt   = (st_nxt == cfg_fuse_pkg::LD_READ) && rd_pend_nxt;
      nvm_addr_nxt = idx_nxt;
      // Leaving idle: strobe word 0 early so its data is ready at capture
      if (st_r == cfg_fuse_pkg::LD_IDLE) begin
         nvm_rd_nxt = 1'b1;
      end
   end

   // Strobe and address registered so the store sees clean levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nvm_rd   <= 1'b0;
         nvm_addr <= 3'h0;
      end else begin
         nvm_rd   <= nvm_rd_nxt;
         nvm_addr <= nvm_addr_nxt;
      end
   end

   // Decode intermediates
   logic [23:0] dbg;
   logic [23:0] opt;
   logic        valid_nxt;
   logic        scan_nxt;
   logic [2:0]  chan_nxt;
   logic [31:0] ivt_nxt;
   logic [31:0] cnt_nxt;
   logic        dmt_dis_nxt;
   logic        spi_nxt;
   logic        smb_nxt;
   logic [2:0]  i2c_nxt;
   logic        chan_rsv_nxt;
   logic        chan_rsv_r;

   // Decode held words; unprogrammed parts decode as erased ones
   always_comb begin
      dbg          = word[cfg_fuse_pkg::IDX_DEBUG];
      opt          = word[cfg_fuse_pkg::IDX_DEVOPT];
      valid_nxt    = (st_r == cfg_fuse_pkg::LD_DONE);
      scan_nxt     = dbg[cfg_fuse_pkg::POS_SCAN_EN];
      chan_rsv_nxt = 1'b0;
      case (dbg[cfg_fuse_pkg::POS_CHAN_LO +: 2])
         cfg_fuse_pkg::CHAN_A:   chan_nxt = 3'b001;
         cfg_fuse_pkg::CHAN_B:   chan_nxt = 3'b010;
         cfg_fuse_pkg::CHAN_C:   chan_nxt = 3'b100;
         default: begin
            // Reserved code: no debug channel is routed, flagged in status
            chan_nxt     = 3'b000;
            chan_rsv_nxt = 1'b1;
         end
      endcase
      // Wide deadman values: high word supplies bits 31:16
      ivt_nxt = {word[cfg_fuse_pkg::IDX_IVT_HI][15:0],
                 word[cfg_fuse_pkg::IDX_IVT_LO][15:0]};
      cnt_nxt = {word[cfg_fuse_pkg::IDX_CNT_HI][15:0],
                 word[cfg_fuse_pkg::IDX_CNT_LO][15:0]};
      dmt_dis_nxt = word[cfg_fuse_pkg::IDX_DMT][cfg_fuse_pkg::POS_DMT_DIS];
      spi_nxt     = opt[cfg_fuse_pkg::POS_SPI_ROUTE];
      smb_nxt     = opt[cfg_fuse_pkg::POS_SMB_EN];
      i2c_nxt     = {opt[cfg_fuse_pkg::POS_I2C3_LOC], opt[cfg_fuse_pkg::POS_I2C2_LOC],
                     opt[cfg_fuse_pkg::POS_I2C1_LOC]};
   end

   // Option outputs registered; erased-one values until each word is captured
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Reset outputs match erased all-ones words
         cfg_valid                 <= 1'b0;
         scan_port_enable          <= 1'b1;
         debug_channel_onehot      <= 3'b001;
         deadman_window_interval   <= cfg_fuse_pkg::ERASED_WIDE;
         deadman_instr_count_limit <= cfg_fuse_pkg::ERASED_WIDE;
         deadman_timer_disable     <= 1'b1;
         second_spi_pin_route      <= 1'b1;
         smbus_threshold_enable    <= 1'b1;
         i2c_default_location      <= 3'b111;
         chan_rsv_r                <= 1'b0;
      end else begin
         cfg_valid                 <= valid_nxt;
         scan_port_enable          <= scan_nxt;
         debug_channel_onehot      <= chan_nxt;
         deadman_window_interval   <= ivt_nxt;
         deadman_instr_count_limit <= cnt_nxt;
         deadman_timer_disable     <= dmt_dis_nxt;
         second_spi_pin_route      <= spi_nxt;
         smbus_threshold_enable    <= smb_nxt;
         i2c_default_location      <= i2c_nxt;
         chan_rsv_r                <= chan_rsv_nxt;
      end
   end

   // Swap gate state
   logic ok_nxt;
   logic rej_nxt;
   logic swp_seen_r;
   logic swp_seen_nxt;

   // Swap instruction gate; requests before load finishes are refused
   // Gated on the registered valid so an answer never runs ahead of cfg_valid
   always_comb begin
      ok_nxt       = 1'b0;
      rej_nxt      = 1'b0;
      swp_seen_nxt = swp_seen_r;
      if (swap_instr_req) begin
         if (cfg_valid && !dbg[cfg_fuse_pkg::POS_SWAP_DIS]) begin
            ok_nxt = 1'b1;
         end else begin
            rej_nxt      = 1'b1;
            swp_seen_nxt = 1'b1;
         end
      end
   end

   // Answers last one cycle; the rejected-seen flag only clears on reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         swap_instr_ok     <= 1'b0;
         swap_instr_reject <= 1'b0;
         swp_seen_r        <= 1'b0;
      end else begin
         swap_instr_ok     <= ok_nxt;
         swap_instr_reject <= rej_nxt;
         swp_seen_r        <= swp_seen_nxt;
      end
   end

   // Read path
   logic [23:0] rd_word;
   logic [31:0] rdata_nxt;

   // Read mux; writes are ignored since the words are program-once
   always_comb begin
      rd_word   = cfg_fuse_pkg::READ_ZERO;
      rdata_nxt = 32'h0000_0000;
      case (reg_addr)
         cfg_fuse_pkg::OFS_DEBUG:  rd_word = word[cfg_fuse_pkg::IDX_DEBUG];
         cfg_fuse_pkg::OFS_IVT_LO: rd_word = word[cfg_fuse_pkg::IDX_IVT_LO];
         cfg_fuse_pkg::OFS_IVT_HI: rd_word = word[cfg_fuse_pkg::IDX_IVT_HI];
         cfg_fuse_pkg::OFS_CNT_LO: rd_word = word[cfg_fuse_pkg::IDX_CNT_LO];
         cfg_fuse_pkg::OFS_CNT_HI: rd_word = word[cfg_fuse_pkg::IDX_CNT_HI];
         cfg_fuse_pkg::OFS_DMT:    rd_word = word[cfg_fuse_pkg::IDX_DMT];
         cfg_fuse_pkg::OFS_DEVOPT: begin
            // Reserved bits show their fixed values regardless of the store
            rd_word = (word[cfg_fuse_pkg::IDX_DEVOPT] & ~cfg_fuse_pkg::RSV_MASK_OPT)
                      | cfg_fuse_pkg::RSV_VAL_OPT;
         end
         cfg_fuse_pkg::OFS_STATUS: begin
            // Status sits above the word slots; reading it has no side effect
            rd_word[cfg_fuse_pkg::POS_ST_VALID]  = cfg_valid;
            rd_word[cfg_fuse_pkg::POS_ST_CHRSV]  = chan_rsv_r;
            rd_word[cfg_fuse_pkg::POS_ST_SWPREJ] = swp_seen_r;
         end
         default: rd_word = cfg_fuse_pkg::READ_ZERO;
      endcase
      if (reg_rd) begin
         rdata_nxt = {8'h00, rd_word};
      end
   end

   // Read data stands for one cycle only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= rdata_nxt;
      end
   end

   // Writes feed nothing: the words are fixed once programmed
   logic unused_ok;
   assign unused_ok = &{1'b0, reg_wr, reg_wdata};
endmodule // device_config_fuse_bank

// ==== hw/cfg_fuse_pkg.sv ====
// Package with layouts, offsets and reset values of the configuration word bank
package cfg_fuse_pkg;
   // Word geometry
   localparam int            WORD_W        = 24;
   localparam int            NUM_WORDS     = 7;
   localparam int            IDX_W         = 3;
   // Word indices in the nonvolatile store and register offsets
   localparam logic [2:0]    IDX_DEBUG     = 3'h0;
   localparam logic [2:0]    IDX_IVT_LO    = 3'h1;
   localparam logic [2:0]    IDX_IVT_HI    = 3'h2;
   localparam logic [2:0]    IDX_CNT_LO    = 3'h3;
   localparam logic [2:0]    IDX_CNT_HI    = 3'h4;
   localparam logic [2:0]    IDX_DMT       = 3'h5;
   localparam logic [2:0]    IDX_DEVOPT    = 3'h6;
   localparam logic [7:0]    OFS_DEBUG     = 8'h00;
   localparam logic [7:0]    OFS_IVT_LO    = 8'h04;
   localparam logic [7:0]    OFS_IVT_HI    = 8'h08;
   localparam logic [7:0]    OFS_CNT_LO    = 8'h0c;
   localparam logic [7:0]    OFS_CNT_HI    = 8'h10;
   localparam logic [7:0]    OFS_DMT       = 8'h14;
   localparam logic [7:0]    OFS_DEVOPT    = 8'h18;
   localparam logic [7:0]    OFS_STATUS    = 8'h1c;
   // Debug word fields
   localparam int            POS_SWAP_DIS  = 15;
   localparam int            POS_RSV_DBG   = 7;
   localparam int            POS_SCAN_EN   = 5;
   localparam int            POS_CHAN_LO   = 0;
   localparam logic [1:0]    CHAN_A        = 2'b11;
   localparam logic [1:0]    CHAN_B        = 2'b10;
   localparam logic [1:0]    CHAN_C        = 2'b01;
   localparam logic [1:0]    CHAN_RSV      = 2'b00;
   // Deadman and device option fields
   localparam int            POS_DMT_DIS   = 0;
   localparam int            POS_SPI_ROUTE = 13;
   localparam int            POS_SMB_EN    = 10;
   localparam int            POS_I2C3_LOC  = 5;
   localparam int            POS_I2C2_LOC  = 4;
   localparam int            POS_I2C1_LOC  = 3;
   // Implemented-bit masks; every other bit reads as one, except options bits 9:8
   localparam logic [23:0]   IMPL_DEBUG    = 24'h00_8023;
   localparam logic [23:0]   IMPL_HALF     = 24'h00_ffff;
   localparam logic [23:0]   IMPL_DMT      = 24'h00_0001;
   localparam logic [23:0]   IMPL_DEVOPT   = 24'h00_2438;
   // Fixed reserved values forced on reserved bits of the options word
   localparam logic [23:0]   RSV_MASK_OPT  = 24'h00_0384;
   localparam logic [23:0]   RSV_VAL_OPT   = 24'h00_0084;
   localparam logic [23:0]   ERASED_WORD   = 24'hff_ffff;
   localparam logic [31:0]   ERASED_WIDE   = 32'hffff_ffff;
   localparam logic [23:0]   READ_ZERO     = 24'h00_0000;
   // Status register bits
   localparam int            POS_ST_VALID  = 0;
   localparam int            POS_ST_CHRSV  = 1;
   localparam int            POS_ST_SWPREJ = 2;
   // Load sequencer
   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_READ = 2'b01,
      LD_DONE = 2'b11
   } load_state_t;
endpackage

// ==== hw/cfg_word_if.sv ====
// Interface carrying one configuration word slot between sequencer and holder
`timescale 1ns/100ps
interface cfg_word_if;
   logic        load;
   logic [23:0] nvm_word;
   logic [23:0] held;
   modport seq    (output load, output nvm_word, input held);
   modport holder (input load, input nvm_word, output held);
endinterface

// ==== hw/cfg_word_hold.sv ====
// One program-once word holder: captured during load, frozen afterward
`timescale 1ns/100ps
module cfg_word_hold #(
   parameter logic [23:0] IMPL_MASK = 24'hff_ffff
) (
   // Clock and reset
   input wire logic         clk,
   input wire logic         rst_n,
   // Word slot
   cfg_word_if.holder       slot
);
   logic [23:0] word_r;
   logic [23:0] word_nxt;

   // Unimplemented positions forced to one on capture
   always_comb begin
      word_nxt = word_r;
      if (slot.load) begin
         word_nxt = slot.nvm_word | ~IMPL_MASK;
      end
   end

   // Erased state reads all ones until the load happens
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_r <= cfg_fuse_pkg::ERASED_WORD;
      end else begin
         word_r <= word_nxt;
      end
   end

   assign slot.held = word_r;
endmodule // cfg_word_hold

// ==== verif/cfg_bank_chk.sv ====
// Port checker for the configuration word bank
`timescale 1ns/100ps
module cfg_bank_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Store and register ports
   input wire logic        nvm_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Swap gate and options
   input wire logic        swap_instr_req,
   input wire logic        swap_instr_ok,
   input wire logic        swap_instr_reject,
   input wire logic        cfg_valid,
   input wire logic        scan_port_enable,
   input wire logic [2:0]  debug_channel_onehot,
   input wire logic [31:0] deadman_window_interval
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Word-aligned offsets up to the status slot are mapped
   logic mapped;
   logic is_word;
   assign mapped  = (reg_addr[1:0] == 2'b00) && (reg_addr <= cfg_fuse_pkg::OFS_STATUS);
   assign is_word = mapped && (reg_addr != cfg_fuse_pkg::OFS_STATUS);
   // A swap request and its single answer
   sequence s_req; swap_instr_req; endsequence
   sequence s_answer; swap_instr_ok ^ swap_instr_reject; endsequence
   rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside answer cycle");
   rd_top_ones_a: assert property (reg_rd && is_word |=> reg_rdata[31:16] == 16'h00ff)
      else $error("unimplemented upper bits do not read one");
   unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   swap_answer_a: assert property (s_req |=> s_answer)
      else $error("swap request without exactly one answer");
   swap_early_a: assert property (swap_instr_req && !cfg_valid |=> swap_instr_reject)
      else $error("swap allowed before load");
   swap_quiet_a: assert property (!swap_instr_req |=> !swap_instr_ok && !swap_instr_reject)
      else $error("swap answer without request");
   valid_sticky_a: assert property (cfg_valid |=> cfg_valid)
      else $error("valid dropped while running");
   load_bound_a: assert property (!cfg_valid |-> ##[1:16] cfg_valid)
      else $error("load did not finish in time");
   held_stable_a: assert property (cfg_valid ##1 cfg_valid |->
      $stable(deadman_window_interval) && $stable(scan_port_enable))
      else $error("held settings changed while running");
   chan_onehot_a: assert property ($onehot0(debug_channel_onehot))
      else $error("more than one debug channel selected");
   store_idle_a: assert property (cfg_valid |-> !nvm_rd)
      else $error("store read after load");
endmodule // cfg_bank_chk
bind device_config_fuse_bank cfg_bank_chk cfg_bank_chk_i (.clk(clk), .rst_n(rst_n),
   .nvm_rd(nvm_rd), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .swap_instr_req(swap_instr_req), .swap_instr_ok(swap_instr_ok),
   .swap_instr_reject(swap_instr_reject), .cfg_valid(cfg_valid),
   .scan_port_enable(scan_port_enable), .debug_channel_onehot(debug_channel_onehot),
   .deadman_window_interval(deadman_window_interval));

// ==== verif/nvm_store_model.sv ====
// Behavioural store holding the programmed configuration image
`timescale 1ns/100ps
module nvm_store_model (
   // Clock
   input  wire logic             clk,
   // Read port from the bank
   input  wire logic [2:0]       nvm_addr,
   input  wire logic             nvm_rd,
   // Programmed image, 0 debug word up to 6 options word
   input  wire logic [6:0][23:0] image,
   output logic [23:0]           nvm_data
);
   logic [23:0] last_r;
   // Last word kept so an idle port can show something stale
   always_ff @(posedge clk) begin
      if (nvm_rd) begin
         last_r <= nvm_data;
      end
   end
   // Idle port shows the inverse, so a late sample cannot pass by luck
   assign nvm_data = nvm_rd ? image[nvm_addr] : ~last_r;
endmodule // nvm_store_model

// ==== verif/device_config_fuse_bank_tb.sv ====
// Self-checking bench of the configuration word bank
`timescale 1ns/100ps
module device_config_fuse_bank_tb;
   logic             clk;
   logic             rst_n;
   logic             reg_rd;
   logic             reg_wr;
   logic             swap_instr_req;
   logic [7:0]       reg_addr;
   logic [31:0]      reg_wdata;
   logic [6:0][23:0] image;
   logic [6:0][23:0] rows [3];
   logic [10:0]      want [3];
   logic [2:0]       nvm_addr;
   logic             nvm_rd;
   logic [23:0]      nvm_data;
   logic [31:0]      reg_rdata;
   logic             swap_instr_ok;
   logic             swap_instr_reject;
   logic             cfg_valid;
   logic             scan_port_enable;
   logic [2:0]       debug_channel_onehot;
   logic [31:0]      deadman_window_interval;
   logic [31:0]      deadman_instr_count_limit;
   logic             deadman_timer_disable;
   logic             second_spi_pin_route;
   logic             smbus_threshold_enable;
   logic [2:0]       i2c_default_location;
   logic [9:0]       opts;
   int               mismatches;
   int               n_tests;
   assign opts = {scan_port_enable, debug_channel_onehot, deadman_timer_disable,
                  second_spi_pin_route, smbus_threshold_enable, i2c_default_location};
   device_config_fuse_bank device_config_fuse_bank_i (.clk(clk), .rst_n(rst_n),
      .nvm_addr(nvm_addr), .nvm_rd(nvm_rd), .nvm_data(nvm_data), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .swap_instr_req(swap_instr_req), .swap_instr_ok(swap_instr_ok),
      .swap_instr_reject(swap_instr_reject), .cfg_valid(cfg_valid),
      .scan_port_enable(scan_port_enable), .debug_channel_onehot(debug_channel_onehot),
      .deadman_window_interval(deadman_window_interval),
      .deadman_instr_count_limit(deadman_instr_count_limit),
      .deadman_timer_disable(deadman_timer_disable),
      .second_spi_pin_route(second_spi_pin_route),
      .smbus_threshold_enable(smbus_threshold_enable),
      .i2c_default_location(i2c_default_location));
   nvm_store_model nvm_store_model_i (.clk(clk), .nvm_addr(nvm_addr), .nvm_rd(nvm_rd),
      .image(image), .nvm_data(nvm_data));
   // Read value of word k: absent bits read one, option reserved bits fixed
   function automatic logic [31:0] exp_reg(input int k, input logic [23:0] w);
      logic [23:0] m;
      m = (k == 0) ? cfg_fuse_pkg::IMPL_DEBUG : (k == 5) ? cfg_fuse_pkg::IMPL_DMT :
          (k == 6) ? cfg_fuse_pkg::IMPL_DEVOPT : cfg_fuse_pkg::IMPL_HALF;
      m = w | ~m;
      if (k == 6) m = (m & ~cfg_fuse_pkg::RSV_MASK_OPT) | cfg_fuse_pkg::RSV_VAL_OPT;
      return {8'h00, m};
   endfunction
   // Drives land 1 ns after the edge, once that edge's updates are visible
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobe stays up so reads can run back to back; idle() drops it
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      tick();
      check(reg_rdata, exp);
   endtask
   task automatic swap_chk(input logic ok_exp);
      swap_instr_req <= 1'b1;
      tick();
      check({30'h0, swap_instr_ok, swap_instr_reject}, {30'h0, ok_exp, ~ok_exp});
   endtask
   task automatic idle();
      reg_rd         <= 1'b0;
      swap_instr_req <= 1'b0;
      tick();
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      tick();
      tick();
      check({21'h0, opts, cfg_valid}, {21'h0, 10'b1_001_1_1_1_111, 1'b0});
      check(deadman_instr_count_limit & deadman_window_interval, 32'hffff_ffff);
      rst_n <= 1'b1;
   endtask
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Watchdog sized far beyond the fewer than one hundred cycles the run needs
   initial begin
      #(5000 * 50);
      mismatches++;
      stop_test();
   end
   // Images keep channel codes legal and reserved bits at their values
   initial begin
      rst_n = 1'b0;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      swap_instr_req = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      mismatches = 0;
      n_tests = 0;
      rows[0] = {24'h00_24bc, 24'h00_0000, 24'h00_def0, 24'h00_9abc, 24'h00_5678,
                 24'h00_1234, 24'h00_00a3};
      rows[1] = {24'h00_0084, 24'h00_0001, 24'h00_ffff, 24'h00_0000, 24'h00_ffff,
                 24'h00_0000, 24'h00_8082};
      rows[2] = {24'h00_0494, 24'h00_0000, 24'h00_8001, 24'h00_7ffe, 24'h00_0f0f,
                 24'h00_f0f0, 24'h00_0081};
      // Expected {swap ok, opts} of each row, worked out by hand
      want[0] = 11'b1_1_001_0_1_1_111;
      want[1] = 11'b0_0_010_1_0_0_000;
      want[2] = 11'b1_0_100_0_0_1_010;
      image = rows[0];
      for (int r = 0; r < 3; r++) begin
         image <= rows[r];
         do_reset();
         swap_chk(1'b0);
         idle();
         for (int i = 0; i < 20 && cfg_valid !== 1'b1; i++) tick();
         check({31'h0, cfg_valid}, 32'h0000_0001);
         for (int k = 0; k < 7; k++) rd_chk(8'(k * 4), exp_reg(k, rows[r][k]));
         rd_chk(cfg_fuse_pkg::OFS_STATUS, 32'h0000_0005);
         rd_chk(8'h20, 32'h0000_0000);
         idle();
         check({22'h0, opts}, {22'h0, want[r][9:0]});
         check(deadman_window_interval, {rows[r][2][15:0], rows[r][1][15:0]});
         check(deadman_instr_count_limit, {rows[r][4][15:0], rows[r][3][15:0]});
         swap_chk(want[r][10]);
         swap_chk(want[r][10]);
         idle();
         $display("Image %0d done", r);
      end
      // Store changes and a write while running must leave settings alone
      image     <= rows[0];
      reg_addr  <= cfg_fuse_pkg::OFS_DEBUG;
      reg_wdata <= 32'h0000_0000;
      reg_wr    <= 1'b1;
      tick();
      reg_wr <= 1'b0;
      rd_chk(cfg_fuse_pkg::OFS_DEBUG, exp_reg(0, rows[2][0]));
      idle();
      check({22'h0, opts}, {22'h0, want[2][9:0]});
      $display("Hold test done");
      stop_test();
   end
endmodule // device_config_fuse_bank_tb
